// ==== rtl/smw_pkg.sv ====
// Shared types and constants for the stop-mode wake-up controller.
// Assumes a single 250 MHz system clock and a synchronous, active-low reset.
package smw_pkg;

   // ==========================================================
   // Sizes
   localparam int PIN_W = 8;
   localparam int RAM_AW = 11;
   localparam int RAM_DW = 8;
   localparam int CLOCK_MHZ = 250;

   // ==========================================================
   // Reset values and field positions
   localparam logic WAKE_FLAG_RESET = 1'b0;
   localparam logic PIN_HOLD_RESET = 1'b0;
   localparam logic [PIN_W-1:0] PIN_OUT_RESET = 8'h00;
   localparam logic [PIN_W-1:0] PIN_OE_RESET = 8'h00;
   localparam int ACK_BIT = 0;

   // ==========================================================
   // Operating modes
   typedef enum logic [1:0] {
      MODE_RUN,
      MODE_SHALLOW_STOP,
      MODE_DEEP_STOP,
      MODE_DEBUG
   } smw_mode_t;

   // Vector selected by the core after a wake or reset
   typedef enum logic [2:0] {
      VEC_NONE,
      VEC_RESET,
      VEC_TIMER,
      VEC_LVD,
      VEC_ADC,
      VEC_EXT_PIN,
      VEC_KEYBOARD
   } smw_vector_t;

   // Debug host commands, as decoded by the serial debug front end
   typedef enum logic [1:0] {
      CMD_MEM_STATUS,
      CMD_HALT,
      CMD_GO,
      CMD_OTHER
   } smw_dbg_cmd_t;

   // Interrupt wake sources, highest priority first
   typedef struct packed {
      logic timer;
      logic low_voltage;
      logic adc;
      logic ext_pin;
      logic keyboard;
   } smw_wake_t;

   // Answer to one debug command
   typedef struct packed {
      logic executed;
      logic stop_error;
   } smw_dbg_resp_t;

   // Pin drive picture: data and enable
   typedef struct packed {
      logic [PIN_W-1:0] data;
      logic [PIN_W-1:0] oe;
   } smw_pins_t;

endpackage : smw_pkg

// ==== rtl/smw_ret_ram.sv ====
// Retained RAM: contents carry no reset, so they survive every reset and stop level.
// Assumes the caller blocks writes whenever the core is halted in stop.
`timescale 1ns/10ps
`default_nettype none
module smw_ret_ram #(
   parameter int AW = smw_pkg::RAM_AW,
   parameter int DW = smw_pkg::RAM_DW
) (
   // Clock
   input wire logic i_clock,
   // Access
   input wire logic i_en,
   input wire logic i_we,
   input wire logic [AW-1:0] i_addr,
   input wire logic [DW-1:0] i_wdata,
   output logic [DW-1:0] o_rdata
);

   // ==========================================================
   // Storage
   logic [DW-1:0] mem [0:(1<<AW)-1];

   // Array and read register have no reset on purpose
   always_ff @(posedge i_clock) begin
      if (i_en) begin
         if (i_we) begin
            mem[i_addr] <= i_wdata;
         end
         o_rdata <= mem[i_addr];
      end
   end

endmodule : smw_ret_ram
`default_nettype wire

// ==== rtl/smw_stop_wakeup.sv ====
// Stop-mode and wake-up controller: deep and shallow stop, pin latching, debug in stop.
// Assumes the core pulses i_stop_exec for one cycle per stop instruction and
// that debug commands arrive already decoded on the system clock.
//
// Notes on behaviour
// - Leaving deep stop sets the wake flag for a recovery routine.
// - Flag and pin latches hold until software writes acknowledge as 1.
// - Unrestored port registers show reset values once latches open.
// - Unconfigured peripheral pins follow port control after latches open.
// - Shallow stop freezes registers, logic and RAM; pins keep following port or peripheral control.
// - Shallow stop ends on reset pin or timer, voltage, ADC, pin, keyboard interrupt.
// - Reset pin exit from shallow stop gives full reset and reset vector.
// - Interrupt exit from shallow stop fetches that source's vector.
// - Debug entry from run only while debug enable is set.
// - Debug enable at stop keeps the debug clocks running.
// - Debug enable in stop keeps the regulator in full regulation.
// - Deep stop request with debug enable gives shallow stop instead.
// - Memory-with-status commands in stop skip the access, report stop error.
// - Halt command with debug enable wakes from shallow stop into debug mode; deep stop ignores it.
// - In debug mode every debug command is accepted and executed.
// - RAM keeps contents across wait, both stop levels and every reset.
`timescale 1ns/10ps
`default_nettype none
module smw_stop_wakeup #(
   parameter int PIN_W = smw_pkg::PIN_W,
   parameter int RAM_AW = smw_pkg::RAM_AW,
   parameter int RAM_DW = smw_pkg::RAM_DW
) (
   // Clock and reset
   input wire logic i_clock,
   input wire logic i_rst_n,
   // External reset pin, asynchronous
   input wire logic i_reset_pin_n,
   // Core stop request and configuration
   input wire logic i_stop_exec,
   input wire logic i_stop_enable,
   input wire logic i_deep_select,
   // Wake sources, asynchronous
   input wire smw_pkg::smw_wake_t i_wake,
   // Acknowledge write
   input wire logic i_ack_write,
   input wire logic [7:0] i_ack_data,
   // Debug
   input wire logic i_debug_mode_enable,
   input wire logic i_dbg_cmd_valid,
   input wire smw_pkg::smw_dbg_cmd_t i_dbg_cmd,
   // Pin sources
   input wire smw_pkg::smw_pins_t i_port_pins,
   input wire smw_pkg::smw_pins_t i_periph_pins,
   input wire logic [PIN_W-1:0] i_periph_en,
   // RAM access from the core
   input wire logic i_ram_en,
   input wire logic i_ram_we,
   input wire logic [RAM_AW-1:0] i_ram_addr,
   input wire logic [RAM_DW-1:0] i_ram_wdata,
   // Mode and clock control
   output smw_pkg::smw_mode_t o_mode,
   output logic o_cpu_clock_en,
   output logic o_debug_clock_en,
   output logic o_regulator_standby,
   // Reset and vector
   output logic o_full_reset,
   output logic o_irq_wake,
   output smw_pkg::smw_vector_t o_vector,
   output logic o_stop_nop,
   // Wake flag and pins
   output logic o_partial_powerdown_wake_flag,
   output logic o_pin_hold,
   output smw_pkg::smw_pins_t o_pins,
   // Debug answer
   output logic o_dbg_resp_valid,
   output smw_pkg::smw_dbg_resp_t o_dbg_resp,
   // RAM read data
   output logic [RAM_DW-1:0] o_ram_rdata
);

   // ==========================================================
   // Input synchronisers
   logic [5:0] sync1_reg;
   logic [5:0] sync2_reg;
   logic pin_rst;
   smw_pkg::smw_wake_t wake;

   // Pins and asynchronous wake lines pass two flops before use
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         sync1_reg <= 6'h20;
         sync2_reg <= 6'h20;
      end else begin
         sync1_reg <= {i_reset_pin_n, i_wake};
         sync2_reg <= sync1_reg;
      end
   end

   assign pin_rst = !sync2_reg[5];
   assign wake = sync2_reg[4:0];

   // ==========================================================
   // Wake source priority
   function automatic smw_pkg::smw_vector_t wake_vector(input smw_pkg::smw_wake_t w);
      smw_pkg::smw_vector_t v;
      v = smw_pkg::VEC_NONE;
      if (w.timer) v = smw_pkg::VEC_TIMER;
      else if (w.low_voltage) v = smw_pkg::VEC_LVD;
      else if (w.adc) v = smw_pkg::VEC_ADC;
      else if (w.ext_pin) v = smw_pkg::VEC_EXT_PIN;
      else if (w.keyboard) v = smw_pkg::VEC_KEYBOARD;
      return v;
   endfunction : wake_vector

   // ==========================================================
   // Mode sequencing
   smw_pkg::smw_mode_t mode_reg;
   smw_pkg::smw_mode_t mode_next;
   logic full_reset_next;
   logic irq_wake_next;
   logic deep_wake_next;
   logic nop_next;
   smw_pkg::smw_vector_t vector_next;
   logic halt_req;
   logic stop_req;
   logic ack;

   assign halt_req = i_dbg_cmd_valid && (i_dbg_cmd == smw_pkg::CMD_HALT) && i_debug_mode_enable;
   assign stop_req = i_stop_exec && (mode_reg == smw_pkg::MODE_RUN);
   assign ack = i_ack_write && i_ack_data[smw_pkg::ACK_BIT];

   // Next mode; the reset pin always beats every other wake cause
   always_comb begin
      mode_next = mode_reg;
      full_reset_next = 1'b0;
      irq_wake_next = 1'b0;
      deep_wake_next = 1'b0;
      nop_next = 1'b0;
      vector_next = smw_pkg::VEC_NONE;
      unique case (mode_reg)
         smw_pkg::MODE_RUN: begin
            if (pin_rst) begin
               full_reset_next = 1'b1;
               vector_next = smw_pkg::VEC_RESET;
            end else if (halt_req) begin
               mode_next = smw_pkg::MODE_DEBUG;
            end else if (stop_req && !i_stop_enable) begin
               nop_next = 1'b1;
            end else if (stop_req && i_deep_select && !i_debug_mode_enable) begin
               mode_next = smw_pkg::MODE_DEEP_STOP;
            end else if (stop_req) begin
               mode_next = smw_pkg::MODE_SHALLOW_STOP;
            end
         end
         smw_pkg::MODE_SHALLOW_STOP: begin
            if (pin_rst) begin
               mode_next = smw_pkg::MODE_RUN;
               full_reset_next = 1'b1;
               vector_next = smw_pkg::VEC_RESET;
            end else if (halt_req) begin
               mode_next = smw_pkg::MODE_DEBUG;
            end else if (wake != '0) begin
               mode_next = smw_pkg::MODE_RUN;
               irq_wake_next = 1'b1;
               vector_next = wake_vector(wake);
            end
         end
         smw_pkg::MODE_DEEP_STOP: begin
            // Deep stop loses core state, so every exit is a full reset
            if (pin_rst || wake.timer || wake.ext_pin) begin
               mode_next = smw_pkg::MODE_RUN;
               full_reset_next = 1'b1;
               deep_wake_next = 1'b1;
               vector_next = smw_pkg::VEC_RESET;
            end
         end
         smw_pkg::MODE_DEBUG: begin
            if (pin_rst) begin
               mode_next = smw_pkg::MODE_RUN;
               full_reset_next = 1'b1;
               vector_next = smw_pkg::VEC_RESET;
            end else if (i_dbg_cmd_valid && i_dbg_cmd == smw_pkg::CMD_GO) begin
               mode_next = smw_pkg::MODE_RUN;
            end
         end
      endcase
   end

   // Mode register and the pulses that go with a transition
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         mode_reg <= smw_pkg::MODE_RUN;
         o_full_reset <= 1'b0;
         o_irq_wake <= 1'b0;
         o_stop_nop <= 1'b0;
         o_vector <= smw_pkg::VEC_NONE;
      end else begin
         mode_reg <= mode_next;
         o_full_reset <= full_reset_next;
         o_irq_wake <= irq_wake_next;
         o_stop_nop <= nop_next;
         o_vector <= vector_next;
      end
   end

   // ==========================================================
   // Clock and regulator control
   logic in_stop_next;

   assign in_stop_next = (mode_next == smw_pkg::MODE_SHALLOW_STOP) ||
                         (mode_next == smw_pkg::MODE_DEEP_STOP);

   // Core clock halts in stop so all state stays frozen
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         o_mode <= smw_pkg::MODE_RUN;
         o_cpu_clock_en <= 1'b1;
         o_debug_clock_en <= 1'b1;
         o_regulator_standby <= 1'b0;
      end else begin
         o_mode <= mode_next;
         o_cpu_clock_en <= (mode_next == smw_pkg::MODE_RUN);
         o_debug_clock_en <= !in_stop_next || i_debug_mode_enable;
         o_regulator_standby <= in_stop_next && !i_debug_mode_enable;
      end
   end

   // ==========================================================
   // Wake flag and pin latches
   logic enter_deep;

   assign enter_deep = (mode_reg == smw_pkg::MODE_RUN) &&
                       (mode_next == smw_pkg::MODE_DEEP_STOP);

   // A wake in the same cycle as the acknowledge keeps the flag set
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         o_partial_powerdown_wake_flag <= smw_pkg::WAKE_FLAG_RESET;
      end else if (deep_wake_next) begin
         o_partial_powerdown_wake_flag <= 1'b1;
      end else if (ack) begin
         o_partial_powerdown_wake_flag <= 1'b0;
      end
   end

   // Latches close on deep entry and open only on acknowledge
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         o_pin_hold <= smw_pkg::PIN_HOLD_RESET;
      end else if (enter_deep) begin
         o_pin_hold <= 1'b1;
      end else if (ack) begin
         o_pin_hold <= 1'b0;
      end
   end

   // Pins: frozen while latched, then peripheral or port control per pin.
   // Port values come from registers the deep-wake reset has returned to
   // their reset values unless software restored them first.
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         o_pins.data <= smw_pkg::PIN_OUT_RESET;
         o_pins.oe <= smw_pkg::PIN_OE_RESET;
      end else if (!o_pin_hold && !enter_deep) begin
         for (int i = 0; i < PIN_W; i++) begin
            if (i_periph_en[i]) begin
               o_pins.data[i] <= i_periph_pins.data[i];
               o_pins.oe[i] <= i_periph_pins.oe[i];
            end else begin
               o_pins.data[i] <= i_port_pins.data[i];
               o_pins.oe[i] <= i_port_pins.oe[i];
            end
         end
      end
   end

   // ==========================================================
   // Debug command answers
   smw_pkg::smw_dbg_resp_t resp_next;

   // Stop refuses everything but halt; memory status commands flag the stop
   always_comb begin
      resp_next = '0;
      unique case (mode_reg)
         smw_pkg::MODE_DEBUG: begin
            resp_next.executed = 1'b1;
         end
         smw_pkg::MODE_SHALLOW_STOP, smw_pkg::MODE_DEEP_STOP: begin
            resp_next.stop_error = (i_dbg_cmd == smw_pkg::CMD_MEM_STATUS);
            resp_next.executed = halt_req;
         end
         smw_pkg::MODE_RUN: begin
            resp_next.executed = (i_dbg_cmd != smw_pkg::CMD_HALT) || i_debug_mode_enable;
         end
      endcase
   end

   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         o_dbg_resp_valid <= 1'b0;
         o_dbg_resp <= '0;
      end else begin
         o_dbg_resp_valid <= i_dbg_cmd_valid;
         o_dbg_resp <= i_dbg_cmd_valid ? resp_next : '0;
      end
   end

   // ==========================================================
   // Retained RAM; writes are blocked while the core is stopped
   logic ram_ok;

   assign ram_ok = (mode_reg == smw_pkg::MODE_RUN) || (mode_reg == smw_pkg::MODE_DEBUG);

   smw_ret_ram #(
      .AW(RAM_AW),
      .DW(RAM_DW)
   ) u_ram (
      .i_clock(i_clock),
      .i_en(i_ram_en && ram_ok),
      .i_we(i_ram_we),
      .i_addr(i_ram_addr),
      .i_wdata(i_ram_wdata),
      .o_rdata(o_ram_rdata)
   );

   // ==========================================================
   // Assertions
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_rst_n);

   sequence s_deep_exit;
      (mode_reg == smw_pkg::MODE_DEEP_STOP) ##1 (mode_reg == smw_pkg::MODE_RUN);
   endsequence

   // Reset pin and halt outrank a stop request, so they are left out here
   sequence s_stop_with_debug;
      stop_req && i_stop_enable && i_debug_mode_enable && !pin_rst && !halt_req;
   endsequence

   deep_wake_flag_a: assert property (
      s_deep_exit |-> o_partial_powerdown_wake_flag && o_full_reset && o_pin_hold)
      else $error("deep stop exit did not set wake flag");

   flag_holds_a: assert property (
      o_partial_powerdown_wake_flag && !ack |=> o_partial_powerdown_wake_flag)
      else $error("wake flag dropped without acknowledge");

   pin_latch_a: assert property (
      o_pin_hold && !ack |=> $stable(o_pins) && o_pin_hold)
      else $error("latched pins changed");

   deep_to_shallow_a: assert property (
      s_stop_with_debug |=> mode_reg == smw_pkg::MODE_SHALLOW_STOP && !o_regulator_standby
         && o_debug_clock_en)
      else $error("debug enable did not force shallow stop");

   stop_nop_a: assert property (
      stop_req && !i_stop_enable && !pin_rst && !halt_req |=>
         o_stop_nop && mode_reg == smw_pkg::MODE_RUN)
      else $error("disallowed stop was not a no-op");

   shallow_reset_a: assert property (
      mode_reg == smw_pkg::MODE_SHALLOW_STOP && pin_rst |=>
         o_full_reset && o_vector == smw_pkg::VEC_RESET && o_cpu_clock_en)
      else $error("reset pin exit lacked reset vector");

   shallow_irq_a: assert property (
      mode_reg == smw_pkg::MODE_SHALLOW_STOP && !pin_rst && !halt_req && wake.timer |=>
         o_irq_wake && o_vector == smw_pkg::VEC_TIMER && !o_full_reset)
      else $error("timer wake took wrong vector");

   stop_mem_err_a: assert property (
      o_mode != smw_pkg::MODE_RUN && o_mode != smw_pkg::MODE_DEBUG && i_dbg_cmd_valid
         && i_dbg_cmd == smw_pkg::CMD_MEM_STATUS |=>
         o_dbg_resp_valid && o_dbg_resp.stop_error && !o_dbg_resp.executed)
      else $error("memory command in stop not refused");

   halt_wake_a: assert property (
      mode_reg == smw_pkg::MODE_SHALLOW_STOP && halt_req && !pin_rst |=>
         mode_reg == smw_pkg::MODE_DEBUG ##1 mode_reg != smw_pkg::MODE_SHALLOW_STOP)
      else $error("halt did not wake into debug");

   debug_exec_a: assert property (
      mode_reg == smw_pkg::MODE_DEBUG && i_dbg_cmd_valid |=> o_dbg_resp.executed)
      else $error("command refused in debug mode");

   debug_gate_a: assert property (
      mode_reg == smw_pkg::MODE_RUN && !i_debug_mode_enable |=> mode_reg != smw_pkg::MODE_DEBUG)
      else $error("debug entered without enable");

endmodule : smw_stop_wakeup
`default_nettype wire

// ==== test/smw_core_model.sv ====
// Behavioural model of the core's port registers, which feed the pin mux.
// Assumes the bench strobes a restore when software copies saved values back.
`timescale 1ns/10ps
`default_nettype none
module smw_core_model (
   // Clock and reset
   input wire logic i_clock,
   input wire logic i_rst_n,
   // Core reset request from the controller
   input wire logic i_full_reset,
   // Software restore of the port registers from RAM
   input wire logic i_restore,
   input wire smw_pkg::smw_pins_t i_restore_val,
   // Port register drive
   output var smw_pkg::smw_pins_t o_port_pins
);
   // ==========================================================
   // Port registers
   // A core reset clears them, so an unrestored port shows reset values
   always_ff @(posedge i_clock) begin
      if (!i_rst_n || i_full_reset) begin
         o_port_pins <= {smw_pkg::PIN_OUT_RESET, smw_pkg::PIN_OE_RESET};
      end else if (i_restore) begin
         o_port_pins <= i_restore_val;
      end
   end
endmodule : smw_core_model
`default_nettype wire

// ==== test/test_stop_mode_wakeup_control.sv ====
// Self-checking bench for the stop-mode wake-up controller.
// Assumes the design's own assertions run alongside; inputs move 1 ns after each edge.
`timescale 1ns/10ps
`default_nettype none
module test_stop_mode_wakeup_control;
   // ==========================================================
   // Wake table: inputs beside the vector they should give
   typedef struct packed {
      logic pin_low;
      smw_pkg::smw_wake_t wake;
      smw_pkg::smw_vector_t vec;
   } smw_row_t;
   localparam smw_row_t ROWS [7] = '{
      '{1'b0, 5'h10, smw_pkg::VEC_TIMER}, '{1'b0, 5'h08, smw_pkg::VEC_LVD},
      '{1'b0, 5'h04, smw_pkg::VEC_ADC}, '{1'b0, 5'h02, smw_pkg::VEC_EXT_PIN},
      '{1'b0, 5'h01, smw_pkg::VEC_KEYBOARD}, '{1'b0, 5'h03, smw_pkg::VEC_EXT_PIN},
      '{1'b1, 5'h01, smw_pkg::VEC_RESET}};
   logic i_clock = 1'b0;
   logic i_rst_n = 1'b0;
   logic rst_pin_n, stop_exec, stop_en, deep_sel, ack_w, dbg_en, cmd_v, ram_en, ram_we;
   logic restore, cpu_en, dbg_clk, reg_sb, full_rst, irq, nop, flag, hold, resp_v;
   logic [7:0] ack_d, periph_en, ram_wd, ram_rd;
   logic [smw_pkg::RAM_AW-1:0] ram_a;
   smw_pkg::smw_wake_t wake;
   smw_pkg::smw_dbg_cmd_t cmd;
   smw_pkg::smw_pins_t port, periph, pins, rest_v;
   smw_pkg::smw_mode_t mode;
   smw_pkg::smw_vector_t vec;
   smw_pkg::smw_dbg_resp_t resp;
   int bad_count = 0;
   int checked = 0;

   // Free-running 250 MHz clock
   always #2 i_clock = ~i_clock;

   smw_stop_wakeup smw_stop_wakeup_i (.i_clock(i_clock), .i_rst_n(i_rst_n),
      .i_reset_pin_n(rst_pin_n), .i_stop_exec(stop_exec), .i_stop_enable(stop_en),
      .i_deep_select(deep_sel), .i_wake(wake), .i_ack_write(ack_w), .i_ack_data(ack_d),
      .i_debug_mode_enable(dbg_en), .i_dbg_cmd_valid(cmd_v), .i_dbg_cmd(cmd),
      .i_port_pins(port), .i_periph_pins(periph), .i_periph_en(periph_en),
      .i_ram_en(ram_en), .i_ram_we(ram_we), .i_ram_addr(ram_a), .i_ram_wdata(ram_wd),
      .o_mode(mode), .o_cpu_clock_en(cpu_en), .o_debug_clock_en(dbg_clk),
      .o_regulator_standby(reg_sb), .o_full_reset(full_rst), .o_irq_wake(irq),
      .o_vector(vec), .o_stop_nop(nop), .o_partial_powerdown_wake_flag(flag),
      .o_pin_hold(hold), .o_pins(pins), .o_dbg_resp_valid(resp_v), .o_dbg_resp(resp),
      .o_ram_rdata(ram_rd));

   smw_core_model smw_core_model_i (.i_clock(i_clock), .i_rst_n(i_rst_n),
      .i_full_reset(full_rst), .i_restore(restore), .i_restore_val(rest_v),
      .o_port_pins(port));

   // ==========================================================
   // Shared tasks
   task automatic step(input int n = 1);
      repeat (n) begin
         @(posedge i_clock);
         #1;
      end
   endtask : step

   // Wide enough for the longest packed compare so no field is silently dropped
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic summarize;
      $display("checks %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : summarize

   // Bounded wait; running out counts as a mismatch and ends the run
   task automatic wait_mode(input smw_pkg::smw_mode_t m);
      for (int i = 0; i < 20; i++) begin
         if (mode === m) return;
         step();
      end
      bad_count++;
      $display("ERROR at %0t: got %h expected %h", $time, mode, m);
      summarize();
   endtask : wait_mode

   task automatic stop(input logic en, input logic deep);
      stop_en = en;
      deep_sel = deep;
      stop_exec = 1'b1;
      step();
      stop_exec = 1'b0;
   endtask : stop

   task automatic send(input smw_pkg::smw_dbg_cmd_t c, input logic [1:0] exp);
      cmd = c;
      cmd_v = 1'b1;
      step();
      cmd_v = 1'b0;
      chk({resp_v, resp}, {1'b1, exp});
      // Let an edge pass so back-to-back commands never retoggle valid in one step
      step();
   endtask : send

   task automatic ack(input logic [7:0] d);
      ack_d = d;
      ack_w = 1'b1;
      step();
      ack_w = 1'b0;
   endtask : ack

   task automatic load(input smw_pkg::smw_pins_t v);
      rest_v = v;
      restore = 1'b1;
      step();
      restore = 1'b0;
   endtask : load

   task automatic ram(input logic we, input logic [7:0] d);
      ram_en = 1'b1;
      ram_we = we;
      ram_wd = d;
      step();
      ram_en = 1'b0;
      ram_we = 1'b0;
   endtask : ram

   task automatic wake_up(input smw_pkg::smw_wake_t w);
      wake = w;
      wait_mode(smw_pkg::MODE_RUN);
   endtask : wake_up

   // ==========================================================
   // Main sequence
   initial begin
      {rst_pin_n, stop_exec, stop_en, deep_sel, ack_w, dbg_en} = 6'h20;
      {cmd_v, ram_en, ram_we, restore} = 4'h0;
      {ack_d, periph_en, ram_wd} = '0;
      ram_a = 11'h7ff;
      wake = '0;
      cmd = smw_pkg::CMD_OTHER;
      {periph, rest_v} = '0;
      step(4);
      i_rst_n = 1'b1;
      chk({mode, cpu_en, dbg_clk, reg_sb, flag, hold, pins}, 23'h180000);
      step(3);
      $display("test reset done");
      // Each wake source from shallow stop, priority and reset pin
      foreach (ROWS[k]) begin
         stop(1'b1, 1'b0);
         chk({mode, cpu_en, reg_sb}, {smw_pkg::MODE_SHALLOW_STOP, 2'b01});
         rst_pin_n = !ROWS[k].pin_low;
         wake_up(ROWS[k].wake);
         chk({vec, full_rst, irq},
            {ROWS[k].vec, ROWS[k].pin_low, !ROWS[k].pin_low});
         wake = '0;
         rst_pin_n = 1'b1;
         step(4);
      end
      $display("test wake table done");
      // RAM survives shallow stop, a write blocked in stop, and a reset
      ram(1'b1, 8'ha5);
      stop(1'b1, 1'b0);
      ram(1'b1, 8'h3c);
      wake_up(5'h01);
      wake = '0;
      step(4);
      i_rst_n = 1'b0;
      step(4);
      i_rst_n = 1'b1;
      step(3);
      ram(1'b0, 8'h00);
      chk(ram_rd, 8'ha5);
      $display("test ram done");
      // Deep stop: flag, latched pins, acknowledge rules
      load({8'ha5, 8'hff});
      step();
      stop(1'b1, 1'b1);
      chk({mode, reg_sb, dbg_clk, hold}, {smw_pkg::MODE_DEEP_STOP, 3'b101});
      load({8'h3c, 8'h0f});
      step(2);
      chk(pins, 16'ha5ff);
      wake_up(5'h10);
      chk({full_rst, vec, flag, hold}, {1'b1, smw_pkg::VEC_RESET, 2'b11});
      wake = '0;
      step(4);
      ack(8'hfe);
      step();
      chk({flag, hold, pins}, 18'h3a5ff);
      ack(8'h01);
      chk({flag, hold}, 2'b00);
      step();
      chk(pins, {smw_pkg::PIN_OUT_RESET, smw_pkg::PIN_OE_RESET});
      // Second deep stop: ports restored, half the pins owned by a peripheral
      periph_en = 8'h0f;
      periph = 16'hffff;
      stop(1'b1, 1'b1);
      wake_up(5'h02);
      wake = '0;
      step(4);
      load({8'h5a, 8'hf0});
      ack(8'h01);
      step();
      chk(pins, 16'h5fff);
      $display("test deep stop done");
      // Debug enabled: deep request becomes shallow, debug kept alive
      dbg_en = 1'b1;
      stop(1'b1, 1'b1);
      chk({mode, dbg_clk, reg_sb}, {smw_pkg::MODE_SHALLOW_STOP, 2'b10});
      send(smw_pkg::CMD_MEM_STATUS, 2'b01);
      send(smw_pkg::CMD_GO, 2'b00);
      chk(mode, smw_pkg::MODE_SHALLOW_STOP);
      send(smw_pkg::CMD_HALT, 2'b10);
      chk({mode, dbg_clk, cpu_en}, {smw_pkg::MODE_DEBUG, 2'b10});
      send(smw_pkg::CMD_MEM_STATUS, 2'b10);
      send(smw_pkg::CMD_OTHER, 2'b10);
      send(smw_pkg::CMD_GO, 2'b10);
      chk(mode, smw_pkg::MODE_RUN);
      send(smw_pkg::CMD_HALT, 2'b10);
      chk(mode, smw_pkg::MODE_DEBUG);
      send(smw_pkg::CMD_GO, 2'b10);
      dbg_en = 1'b0;
      send(smw_pkg::CMD_HALT, 2'b00);
      chk(mode, smw_pkg::MODE_RUN);
      stop(1'b0, 1'b1);
      chk({mode, nop}, {smw_pkg::MODE_RUN, 1'b1});
      $display("test debug done");
      summarize();
   end
endmodule : test_stop_mode_wakeup_control
`default_nettype wire
